/* core/csp_pkg.sv */
// Constants, register map and carrier types for the clocked serial port
package csp_pkg;

   // ==========================================================
   // Bus geometry
   localparam int CSP_ADDR_W = 12;
   localparam int CSP_DATA_W = 32;
   localparam int CSP_NCH = 2;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] CSP_IDX_S3_CTRL = 8'hDC;
   localparam logic [7:0] CSP_IDX_S3_DATA = 8'hDD;
   localparam logic [7:0] CSP_IDX_S1_CTRL = 8'hE0;
   localparam logic [7:0] CSP_IDX_S1_DATA = 8'hE1;
   localparam logic [7:0] CSP_IDX_IRQ_STAT = 8'hE2;
   localparam logic [7:0] CSP_IDX_IRQ_MASK = 8'hE3;

   // ==========================================================
   // Control register field positions
   localparam int CSP_B_DONE = 0;
   localparam int CSP_B_GO = 1;
   localparam int CSP_B_CLK_LO = 2;
   localparam int CSP_B_CLK_HI = 3;
   localparam int CSP_B_MODE_LO = 4;
   localparam int CSP_B_S1_MODE_HI = 5;
   localparam int CSP_B_S1_POL = 6;
   localparam int CSP_B_S1_PINSEL = 7;
   localparam int CSP_B_S3_POL = 5;
   localparam logic [7:0] CSP_CTRL_RESET = 8'h01;
   localparam logic [7:0] CSP_DATA_RESET = 8'h00;

   // ==========================================================
   // Clock sources and modes
   localparam logic [1:0] CSP_CLK_DIV4 = 2'h0;
   localparam logic [1:0] CSP_CLK_DIV16 = 2'h1;
   localparam logic [1:0] CSP_CLK_TIMER = 2'h2;
   localparam logic [1:0] CSP_CLK_EXT = 2'h3;
   localparam logic [1:0] CSP_MODE_PORT = 2'h0;
   localparam logic [1:0] CSP_MODE_SEND = 2'h1;
   localparam logic [1:0] CSP_MODE_RECV = 2'h2;
   localparam logic [1:0] CSP_MODE_BOTH = 2'h3;

   // ==========================================================
   // Timing: serial clock periods in oscillator cycles, halved per edge
   localparam int CSP_DIV_A = 4;
   localparam int CSP_DIV_B = 16;
   localparam logic [3:0] CSP_HALF_A = 4'(CSP_DIV_A / 2 - 1);
   localparam logic [3:0] CSP_HALF_B = 4'(CSP_DIV_B / 2 - 1);
   localparam int CSP_EXT_MAX_KHZ = 1000;
   localparam logic [2:0] CSP_LAST_BIT = 3'h7;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic pinsel;
      logic serial1_edge_polarity;
      logic [1:0] mode;
      logic [1:0] clksel;
   } csp_cfg_s;

   typedef enum logic [2:0] {
      CSP_SEL_NONE,
      CSP_SEL_CTRL3,
      CSP_SEL_DATA3,
      CSP_SEL_CTRL1,
      CSP_SEL_DATA1,
      CSP_SEL_STAT,
      CSP_SEL_MASK
   } csp_sel_e;

endpackage : csp_pkg

/* core/csp_top.sv */
// Two-channel clocked serial port with Avalon-MM register access
// Function
// - Start bit launches a transfer; hardware clears it after one serial clock cycle
// - Default polarity: drive on falling edge, sample on rising edge
// - Polarity one swaps edges: drive on rising, sample on falling
// - After eight pulses: counter to zero, clock parked high, interrupt raised
// - Exactly eight bits per transfer, least significant bit first both ways
// - Clock source: 00 osc/4, 01 osc/16, 10 timer overflow, 11 external pin
// - Status flag reads 0 during transfer and 1 once finished
// - Send-only mode bit 0 leaves pins as port, 1 hands them to serial
// - Full channel data pin is two-way; receive input pin chosen by select bit
// - Completion sets status flag and interrupt; received byte read from data register
// - Send-only control at 0DC, data at 0DD; control resets to 0000 0001
`timescale 1ns/100ps
module csp_top (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [csp_pkg::CSP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [csp_pkg::CSP_DATA_W-1:0] avs_writedata,
   output logic [csp_pkg::CSP_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic timer0_overflow_tick,
   input wire logic serial1_data_pin_in,
   output logic serial1_data_pin_out,
   output logic serial1_data_pin_oe,
   input wire logic serial1_data_in,
   input wire logic serial1_clock_in,
   output logic serial1_clock_out,
   output logic serial1_clock_oe,
   output logic serial3_data_out_pin,
   output logic serial3_data_out_oe,
   input wire logic serial3_clock_pin_in,
   output logic serial3_clock_pin_out,
   output logic serial3_clock_pin_oe
);
   import csp_pkg::*;

   // ==========================================================
   // Register decode helpers
   function automatic csp_sel_e decode_sel(input logic [CSP_ADDR_W-1:0] a);
      csp_sel_e s;
      s = CSP_SEL_NONE;
      if (a[1:0] == 2'h0 && a[CSP_ADDR_W-1:10] == '0) begin
         unique case (a[9:2])
            CSP_IDX_S3_CTRL: s = CSP_SEL_CTRL3;
            CSP_IDX_S3_DATA: s = CSP_SEL_DATA3;
            CSP_IDX_S1_CTRL: s = CSP_SEL_CTRL1;
            CSP_IDX_S1_DATA: s = CSP_SEL_DATA1;
            CSP_IDX_IRQ_STAT: s = CSP_SEL_STAT;
            CSP_IDX_IRQ_MASK: s = CSP_SEL_MASK;
            default: s = CSP_SEL_NONE;
         endcase
      end
      return s;
   endfunction : decode_sel

   // Full channel uses the wide layout, send-only the narrow one
   function automatic csp_cfg_s cfg_from_byte(input logic [7:0] b, input logic full);
      csp_cfg_s c;
      c.clksel = {b[CSP_B_CLK_HI], b[CSP_B_CLK_LO]};
      if (full) begin
         c.mode = {b[CSP_B_S1_MODE_HI], b[CSP_B_MODE_LO]};
         c.serial1_edge_polarity = b[CSP_B_S1_POL];
         c.pinsel = b[CSP_B_S1_PINSEL];
      end else begin
         c.mode = {1'b0, b[CSP_B_MODE_LO]};
         c.serial1_edge_polarity = b[CSP_B_S3_POL];
         c.pinsel = 1'b0;
      end
      return c;
   endfunction : cfg_from_byte

   function automatic logic [7:0] ctrl_to_byte(input csp_cfg_s c, input logic go,
                                               input logic done, input logic full);
      logic [7:0] b;
      b = 8'h00;
      b[CSP_B_DONE] = done;
      b[CSP_B_GO] = go;
      b[CSP_B_CLK_LO] = c.clksel[0];
      b[CSP_B_CLK_HI] = c.clksel[1];
      b[CSP_B_MODE_LO] = c.mode[0];
      if (full) begin
         b[CSP_B_S1_MODE_HI] = c.mode[1];
         b[CSP_B_S1_POL] = c.serial1_edge_polarity;
         b[CSP_B_S1_PINSEL] = c.pinsel;
      end else begin
         b[CSP_B_S3_POL] = c.serial1_edge_polarity;
      end
      return b;
   endfunction : ctrl_to_byte

   // ==========================================================
   // Avalon slave handshake: one wait cycle per access
   logic ack_q;
   logic req;
   logic wr_fire;
   logic rd_take;
   csp_sel_e sel;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_fire = avs_write & ack_q & avs_byteenable[0];
   assign rd_take = avs_read & ~ack_q;
   assign sel = decode_sel(avs_address);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // ==========================================================
   // Shared oscillator divider for the internal shift clocks
   logic [3:0] div_q;
   logic half_a;
   logic half_b;

   assign half_a = (div_q & CSP_HALF_A) == CSP_HALF_A;
   assign half_b = (div_q & CSP_HALF_B) == CSP_HALF_B;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // ==========================================================
   // Channel engines: index 0 is the full channel, 1 the send-only one
   csp_cfg_s cfg_q [CSP_NCH];
   logic go_q [CSP_NCH];
   logic done_q [CSP_NCH];
   logic busy_q [CSP_NCH];
   logic sck_q [CSP_NCH];
   logic dout_q [CSP_NCH];
   logic ext_q [CSP_NCH];
   logic [2:0] cnt_q [CSP_NCH];
   logic [7:0] sreg_q [CSP_NCH];
   logic [CSP_NCH-1:0] done_evt;
   logic [CSP_NCH-1:0] active;
   logic [CSP_NCH-1:0] sin;
   logic [CSP_NCH-1:0] ext_in;
   csp_sel_e sel_ctrl [CSP_NCH];
   csp_sel_e sel_data [CSP_NCH];

   assign sel_ctrl[0] = CSP_SEL_CTRL1;
   assign sel_data[0] = CSP_SEL_DATA1;
   assign sel_ctrl[1] = CSP_SEL_CTRL3;
   assign sel_data[1] = CSP_SEL_DATA3;
   assign sin[0] = cfg_q[0].pinsel ? serial1_data_in : serial1_data_pin_in;
   // Send-only channel has no input; zeros fill the register behind the data
   assign sin[1] = 1'b0;
   assign ext_in[0] = serial1_clock_in;
   assign ext_in[1] = serial3_clock_pin_in;

   for (genvar g = 0; g < CSP_NCH; g++) begin : g_ch
      logic full;
      logic half;
      logic internal;
      logic fall_e;
      logic rise_e;
      logic drive_e;
      logic samp_e;
      logic start;

      assign full = (g == 0);
      // mode field gates the serial function
      assign active[g] = cfg_q[g].mode != CSP_MODE_PORT;
      always_comb begin
         unique case (cfg_q[g].clksel)
            CSP_CLK_DIV4: half = half_a;
            CSP_CLK_DIV16: half = half_b;
            CSP_CLK_TIMER: half = timer0_overflow_tick;
            CSP_CLK_EXT: half = 1'b0;
         endcase
      end
      assign internal = cfg_q[g].clksel != CSP_CLK_EXT;
      assign fall_e = internal ? (half & sck_q[g]) : (ext_q[g] & ~ext_in[g]);
      assign rise_e = internal ? (half & ~sck_q[g]) : (~ext_q[g] & ext_in[g]);
      // polarity picks drive and sample edges
      assign drive_e = cfg_q[g].serial1_edge_polarity ? rise_e : fall_e;
      assign samp_e = cfg_q[g].serial1_edge_polarity ? fall_e : rise_e;
      // start only honoured in a serial mode and when idle
      assign start = wr_fire && sel == sel_ctrl[g] && avs_writedata[CSP_B_GO]
                     && cfg_from_byte(avs_writedata[7:0], full).mode != CSP_MODE_PORT
                     && !busy_q[g];

      // Configuration fields, held steady while a transfer runs
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            cfg_q[g] <= cfg_from_byte(CSP_CTRL_RESET, g == 0);
         end else if (wr_fire && sel == sel_ctrl[g] && !busy_q[g]) begin
            cfg_q[g] <= cfg_from_byte(avs_writedata[7:0], full);
         end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            // Matches the idle-high pin so no false edge follows reset
            ext_q[g] <= 1'b1;
         end else begin
            ext_q[g] <= ext_in[g];
         end
      end

      // Shift engine
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            go_q[g] <= 1'b0;
            done_q[g] <= CSP_CTRL_RESET[CSP_B_DONE];
            busy_q[g] <= 1'b0;
            sck_q[g] <= 1'b1;
            dout_q[g] <= 1'b1;
            cnt_q[g] <= 3'h0;
            sreg_q[g] <= CSP_DATA_RESET;
            done_evt[g] <= 1'b0;
         end else begin
            done_evt[g] <= 1'b0;
            if (start) begin
               go_q[g] <= 1'b1;
               done_q[g] <= 1'b0;
               busy_q[g] <= 1'b1;
               sck_q[g] <= 1'b1;
               cnt_q[g] <= 3'h0;
               dout_q[g] <= sreg_q[g][0];
            end else if (busy_q[g]) begin
               if (internal && half) begin
                  sck_q[g] <= ~sck_q[g];
               end
               if (drive_e) begin
                  dout_q[g] <= sreg_q[g][0];
               end
               if (samp_e) begin
                  // incoming bits enter at the top
                  sreg_q[g] <= {sin[g], sreg_q[g][7:1]};
                  cnt_q[g] <= cnt_q[g] + 3'h1;
               end
               // start bit drops after first full serial clock cycle
               if (rise_e) begin
                  go_q[g] <= 1'b0;
               end
               // eighth pulse ends on its rising edge, so polarity one still shows it
               if (rise_e && (cfg_q[g].serial1_edge_polarity ? (cnt_q[g] == 3'h0 && !go_q[g])
                                           : cnt_q[g] == CSP_LAST_BIT)) begin
                  // stop, park clock high, counter wraps to zero
                  busy_q[g] <= 1'b0;
                  sck_q[g] <= 1'b1;
                  done_q[g] <= 1'b1;
                  done_evt[g] <= 1'b1;
               end
            end else if (wr_fire && sel == sel_data[g]) begin
               // Data writes during a transfer would corrupt the shift, so they are dropped
               sreg_q[g] <= avs_writedata[7:0];
            end
         end
      end
   end

   // ==========================================================
   // Pin steering
   always_comb begin
      serial1_data_pin_out = dout_q[0];
      // two-way data pin released in receive mode
      serial1_data_pin_oe = active[0] && cfg_q[0].mode != CSP_MODE_RECV;
      serial1_clock_out = sck_q[0];
      serial1_clock_oe = active[0] && cfg_q[0].clksel != CSP_CLK_EXT;
      // send-only pins driven only in sending mode
      serial3_data_out_pin = dout_q[1];
      serial3_data_out_oe = active[1];
      serial3_clock_pin_out = sck_q[1];
      serial3_clock_pin_oe = active[1] && cfg_q[1].clksel != CSP_CLK_EXT;
   end

   // ==========================================================
   // Interrupt status (write one to clear) and mask
   logic [CSP_NCH-1:0] stat_q;
   logic [CSP_NCH-1:0] mask_q;
   logic [CSP_NCH-1:0] stat_clr;

   assign stat_clr = (wr_fire && sel == CSP_SEL_STAT) ? avs_writedata[CSP_NCH-1:0] : '0;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_q <= '0;
      end else begin
         // new completion wins over a simultaneous clear
         stat_q <= (stat_q & ~stat_clr) | done_evt;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= '0;
      end else if (wr_fire && sel == CSP_SEL_MASK) begin
         mask_q <= avs_writedata[CSP_NCH-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // ==========================================================
   // Read data, captured in the wait cycle; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= '0;
      end else if (rd_take) begin
         avs_readdata <= '0;
         unique case (sel)
            // status and start bits read back live
            CSP_SEL_CTRL3: avs_readdata[7:0] <= ctrl_to_byte(cfg_q[1], go_q[1], done_q[1], 1'b0);
            // send-only data register reads the shift register, zero-filled by a transfer
            CSP_SEL_DATA3: avs_readdata[7:0] <= sreg_q[1];
            CSP_SEL_CTRL1: avs_readdata[7:0] <= ctrl_to_byte(cfg_q[0], go_q[0], done_q[0], 1'b1);
            CSP_SEL_DATA1: avs_readdata[7:0] <= sreg_q[0];
            CSP_SEL_STAT: avs_readdata[CSP_NCH-1:0] <= stat_q;
            CSP_SEL_MASK: avs_readdata[CSP_NCH-1:0] <= mask_q;
            CSP_SEL_NONE: avs_readdata <= '0;
         endcase
      end
   end

endmodule : csp_top

/* sim/csp_top_asserts.sv */
// Port-level assertion checker for the clocked serial port
`timescale 1ns/100ps
module csp_top_asserts (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [csp_pkg::CSP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [csp_pkg::CSP_DATA_W-1:0] avs_writedata,
   input wire logic [csp_pkg::CSP_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic serial3_data_out_pin,
   input wire logic serial3_data_out_oe,
   input wire logic serial3_clock_pin_in,
   input wire logic serial3_clock_pin_out,
   input wire logic serial3_clock_pin_oe
);
   import csp_pkg::*;
   localparam logic [11:0] A_STAT = {2'b00, CSP_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_MASK = {2'b00, CSP_IDX_IRQ_MASK, 2'b00};
   wire req = avs_read | avs_write;
   wire ack = req & ~avs_waitrequest;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // Register bus
   AST_FIRST_WAIT: assert property ($rose(req) |-> avs_waitrequest)
      else $error("no wait cycle at start of access");
   AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   AST_IDLE_FREE: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest high with no access");
   AST_UNMAPPED_ZERO: assert property (avs_read && ack && avs_address == 12'h000 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_UPPER_ZERO: assert property (avs_read && ack |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data bits set");
   // ==========================================================
   // Send-only link pins
   AST_CLK_NEEDS_MODE: assert property (serial3_clock_pin_oe |-> serial3_data_out_oe)
      else $error("serial clock driven in port mode");
   // Data moves only on a clock edge or at the start load
   AST_DATA_EDGE: assert property ($changed(serial3_data_out_pin) && serial3_data_out_oe
      && $past(serial3_data_out_oe) |-> $changed(serial3_clock_pin_out) || $past(avs_write)
      || serial3_clock_pin_in != $past(serial3_clock_pin_in, 3))
      else $error("serial data changed away from a clock edge");
   AST_CLK_PARK: assert property (serial3_clock_pin_oe && !serial3_clock_pin_out
      |-> ##[1:40] serial3_clock_pin_out)
      else $error("serial clock stuck low");
   // ==========================================================
   // Interrupt
   AST_IRQ_CLEAR: assert property (avs_write && ack && avs_address == A_STAT
      && avs_writedata[1:0] == 2'h3 && avs_byteenable[0] |-> ##2 !irq)
      else $error("irq still high after status clear");
   AST_IRQ_MASKED: assert property (avs_write && ack && avs_address == A_MASK
      && avs_writedata[1:0] == 2'h0 && avs_byteenable[0] |-> ##2 !irq)
      else $error("irq high with all sources masked");
endmodule : csp_top_asserts

bind csp_top csp_top_asserts i_csp_top_asserts (
   .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
   .serial3_data_out_pin(serial3_data_out_pin), .serial3_data_out_oe(serial3_data_out_oe),
   .serial3_clock_pin_in(serial3_clock_pin_in), .serial3_clock_pin_out(serial3_clock_pin_out),
   .serial3_clock_pin_oe(serial3_clock_pin_oe)
);

/* sim/csp_peer.sv */
// Serial peripheral model: an 8-bit shift register on one clocked link
`timescale 1ns/100ps
module csp_peer (
   input wire logic sys_clk,
   input wire logic sclk,
   input wire logic sdo,
   input wire logic serial1_edge_polarity,
   input wire logic [7:0] tx,
   output logic sdi,
   output logic [7:0] rx,
   output logic got
);
   logic sclk_q = 1'b1;
   logic [3:0] idx = 4'h0;
   logic [2:0] bi = 3'h0;
   // sample and drive edges swap with polarity
   wire smp = serial1_edge_polarity ? (sclk_q & ~sclk) : (sclk & ~sclk_q);
   wire drv = serial1_edge_polarity ? (sclk & ~sclk_q) : (sclk_q & ~sclk);
   assign sdi = tx[bi];
   initial rx = 8'h00;
   initial got = 1'b0;
   // ==========================================================
   // Shifting; reacts one system clock late, fine at these rates
   always @(posedge sys_clk) begin
      sclk_q <= sclk;
      got <= 1'b0;
      if (drv) begin
         bi <= idx[2:0];
      end
      if (smp) begin
         rx <= {sdo, rx[7:1]};
         idx <= (idx == 4'h7) ? 4'h0 : idx + 4'h1;
         if (idx == 4'h7) begin
            got <= 1'b1;
            bi <= 3'h0;
         end
      end
   end
endmodule : csp_peer

/* sim/csp_top_bench.sv */
// Self-checking testbench for the clocked serial port
`timescale 1ns/100ps
module csp_top_bench;
   import csp_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [CSP_ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [CSP_DATA_W-1:0] avs_writedata = '0;
   logic [CSP_DATA_W-1:0] avs_readdata;
   logic avs_waitrequest, irq, s1_out, s1_oe, s1_clk, s1_coe, s3_dat, s3_doe, s3_clk, s3_coe;
   logic tick = 1'b0, ext_clk = 1'b1, alt = 1'b0, pol1 = 1'b0, serial3_edge_polarity = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [7:0] tx1 = 8'h00, d, p1_rx, p3_rx;
   logic p1_sdi, p1_got, p3_got;
   logic [63:0] e;
   logic [63:0] rd_q[$], s1_q[$], s3_q[$];
   int seed = 75;
   int bad_count = 0;
   int checks = 0;
   wire pin1 = s1_oe ? s1_out : (alt ? ~p1_sdi : p1_sdi);
   csp_top i_csp_top (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .timer0_overflow_tick(tick),
      .serial1_data_pin_in(pin1), .serial1_data_pin_out(s1_out), .serial1_data_pin_oe(s1_oe),
      .serial1_data_in(alt ? p1_sdi : ~p1_sdi), .serial1_clock_in(ext_clk),
      .serial1_clock_out(s1_clk), .serial1_clock_oe(s1_coe), .serial3_data_out_pin(s3_dat),
      .serial3_data_out_oe(s3_doe), .serial3_clock_pin_in(ext_clk),
      .serial3_clock_pin_out(s3_clk), .serial3_clock_pin_oe(s3_coe));
   csp_peer i_peer1 (.sys_clk(sys_clk), .sclk(s1_coe ? s1_clk : 1'b1), .sdo(s1_out),
      .serial1_edge_polarity(pol1), .tx(tx1), .sdi(p1_sdi), .rx(p1_rx), .got(p1_got));
   csp_peer i_peer3 (.sys_clk(sys_clk), .sclk(s3_coe ? s3_clk : ext_clk), .sdo(s3_dat),
      .serial1_edge_polarity(serial3_edge_polarity), .tx(8'h00), .sdi(), .rx(p3_rx), .got(p3_got));
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   // ==========================================================
   // Checking helpers
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ad
   function automatic logic [63:0] pop(ref logic [63:0] q[$]);
      return (q.size() != 0) ? q.pop_front() : {32'hFFFFFFFF, 32'hx};
   endfunction : pop
   task automatic close_out();
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] m,
      input logic [31:0] g);
      checks++;
      if ((g & m) !== (x & m)) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x & m, g & m);
      end
   endtask : chk
   // Results are compared as they appear, oldest note first
   always @(posedge sys_clk) begin
      if (avs_read && !avs_waitrequest) begin
         e = pop(rd_q);
         chk("readdata", e[31:0], e[63:32], avs_readdata);
      end
      if (p3_got) begin
         e = pop(s3_q);
         chk("serial3 byte", e[31:0], e[63:32], {24'h0, p3_rx});
      end
      if (p1_got) begin
         e = pop(s1_q);
         chk("serial1 byte", e[31:0], e[63:32], {24'h0, p1_rx});
      end
   end
   // ==========================================================
   // Bus and wait tasks; every wait is bounded
   task automatic wait_for(input bit on_irq, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while ((on_irq ? !irq : avs_waitrequest) && n < lim);
      if (on_irq ? !irq : avs_waitrequest) begin
         bad_count++;
         close_out();
      end
   endtask : wait_for
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      avs_address <= a;
      avs_writedata <= {24'h0, v};
      avs_write <= 1'b1;
      wait_for(1'b0, 20);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
      rd_q.push_back({m, x});
      avs_address <= a;
      avs_read <= 1'b1;
      wait_for(1'b0, 20);
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : rd
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(ad(CSP_IDX_S3_CTRL), 32'h01, 32'hFF);
      rd(12'h000, 32'h0, 32'hFFFFFFFF);
      wr(ad(CSP_IDX_IRQ_MASK), 8'h03);
      for (int c = 0; c < 4; c++) begin
         d = 8'($random(seed));
         serial3_edge_polarity <= c[0];
         wr(ad(CSP_IDX_S3_DATA), d);
         s3_q.push_back({32'hFF, 24'h0, d});
         wr(ad(CSP_IDX_S3_CTRL), {2'b00, c[0], 1'b1, c[1:0], 2'b10});
         wr(ad(CSP_IDX_S3_DATA), ~d);
         rd(ad(CSP_IDX_S3_CTRL), 32'h2, c[0] ? 32'h3 : 32'h1);
         // External clock: 8 pulses of 260 cycles, under 1 MHz, even duty
         for (int p = 0; p < 8 && c == 3; p++) begin
            repeat (130) @(posedge sys_clk);
            ext_clk <= 1'b0;
            repeat (130) @(posedge sys_clk);
            ext_clk <= 1'b1;
         end
         wait_for(1'b1, 4000);
         rd(ad(CSP_IDX_S3_CTRL), {2'b00, c[0], 1'b1, c[1:0], 2'b01}, 32'hFF);
         rd(ad(CSP_IDX_IRQ_STAT), 32'h2, 32'h3);
         wr(ad(CSP_IDX_IRQ_STAT), 8'h03);
         rd(ad(CSP_IDX_IRQ_STAT), 32'h0, 32'h3);
      end
      for (int m = 1; m < 4; m++) begin
         d = 8'($random(seed));
         tx1 <= ~d;
         alt <= (m == 3);
         pol1 <= m[0];
         wr(ad(CSP_IDX_S1_CTRL), {(m == 3), m[0], m[1:0], 2'(m - 1), 2'b00});
         wr(ad(CSP_IDX_S1_DATA), d);
         s1_q.push_back({m[0] ? 32'hFF : 32'h0, 24'h0, d});
         wr(ad(CSP_IDX_S1_CTRL), {(m == 3), m[0], m[1:0], 2'(m - 1), 2'b10});
         wait_for(1'b1, 4000);
         rd(ad(CSP_IDX_S1_DATA), {24'h0, ~d}, m[1] ? 32'hFF : 32'h0);
         rd(ad(CSP_IDX_IRQ_STAT), 32'h1, 32'h3);
         if (m < 3) wr(ad(CSP_IDX_IRQ_STAT), 8'h03);
      end
      // Masking hides the interrupt but the status stays sticky
      wr(ad(CSP_IDX_IRQ_MASK), 8'h00);
      rd(ad(CSP_IDX_IRQ_STAT), 32'h1, 32'h3);
      chk("irq", 32'h0, 32'h1, {31'h0, irq});
      repeat (4) @(posedge sys_clk);
      close_out();
   end
endmodule : csp_top_bench
